// *** common/mspsc_flag_if.sv ***
`timescale 1ns/1ps
interface mspsc_flag_if #(parameter int W = 7);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic         clr_all;
  logic [W-1:0] flags;

  modport owner (input set, input clr, input clr_all, output flags);
  modport user  (output set, output clr, output clr_all, input flags);
endinterface

// *** common/mspsc_pkg.sv ***
package mspsc_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 25;
  localparam int CLK_MHZ       = 40;

  // strap sampling window after reset release, least time
  localparam int STRAP_SAMPLE_NS  = 1000;
  localparam int STRAP_SAMPLE_CYC =
    (STRAP_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_CNT_W     = 6;

  // power-down to run wake time, typical
  localparam int WAKE_TIME_US     = 1410;
  localparam int WAKE_DELAY_CYC   = WAKE_TIME_US * CLK_MHZ;
  localparam int WAKE_CNT_W       = 16;

  // config_reg_zero bit positions
  localparam int CFG_IDLE_BIT     = 5;
  localparam int CFG_THERMAL_BIT  = 6;
  localparam int CFG_SLEEP_BIT    = 7;

  // flash_control_reg bit positions
  localparam int FC_PROGRAM_BIT   = 3;
  localparam int FC_ERASE_BIT     = 2;
  localparam logic [7:0] FC_RESET = 8'h00;

  localparam logic [15:0] APP_START_ADDR = 16'h4000;

  // widths of event groups, wake flag bit positions
  localparam int IRQ_W            = 10;
  localparam int RESUME_W         = 7;
  localparam int WAKE_SRC_W       = 5;
  localparam int WAKE_FLAG_W      = 7;
  localparam int WF_WATCHDOG_BIT  = 5;
  localparam int WF_THERMAL_BIT   = 6;

  // strap codes, mode_strap_a in the upper bit
  localparam logic [1:0] STRAP_TEST  = 2'h0;
  localparam logic [1:0] STRAP_FLASH_PROGRAM_BIT  = 2'h1;
  localparam logic [1:0] STRAP_DEBUG = 2'h2;

  typedef enum logic [2:0] {
    MODE_BOOT   = 3'h0,
    MODE_NORMAL = 3'h1,
    MODE_DEBUG  = 3'h3,
    MODE_FLASH_PROGRAM_BIT   = 3'h2,
    MODE_TEST   = 3'h6,
    MODE_SCAN   = 3'h7
  } mspsc_mode_type;

  typedef enum logic [2:0] {
    PS_INIT  = 3'h0,
    PS_RUN   = 3'h1,
    PS_IDLE  = 3'h3,
    PS_SLEEP = 3'h2,
    PS_WAKE  = 3'h6,
    PS_THERM = 3'h7,
    PS_HOLD  = 3'h4
  } mspsc_pwr_type;

endpackage

// *** dv/mspsc_ctrl_bench.sv ***
`timescale 1ns/1ps
module mspsc_ctrl_bench;
  import mspsc_pkg::*;
  localparam int WK = 8;
  logic ref_clk_in = 1'b0, reset_in = 1'b1, scan_entry_pin_in = 1'b0;
  logic debug_program_lock_in = 1'b0, overtemp_detector_in = 1'b0;
  logic boot_done_in = 1'b1, cfg_wr_in = 1'b0, reti_in = 1'b0;
  logic resume_capable_active_in = 1'b0, wd_overflow_in = 1'b0;
  logic flash_ctrl_wr_in = 1'b0, ram_retain_in = 1'b0;
  logic [7:0] cfg_data_in = 8'h00, flash_ctrl_data_in = 8'h00;
  logic [RESUME_W-1:0] resume_src_in = '0, resume_clr_in = '0;
  logic [IRQ_W-1:0] irq_req_in = '0;
  logic [WAKE_SRC_W-1:0] wake_src_in = '0;
  logic [WAKE_FLAG_W-1:0] wake_clr_in = '0, wake_flag_reg_out;
  logic [2:0] code = 3'h0;
  wire strap_select_enable_pin_in, mode_strap_a_in, mode_strap_b_in;
  mspsc_mode_type mode_out;
  mspsc_pwr_type power_state_out;
  logic [1:0] strap_latch_out;
  logic cpu_clk_en_out, cpu_power_out, periph_power_out, ram_low_power_out;
  logic periph_reset_out, app_start_out, wd_clear_out;
  logic [15:0] start_addr_out;
  logic [RESUME_W-1:0] resume_flag_out;
  logic [7:0] flash_control_reg_out;
  int n_errors = 0, n_compared = 0, k;

  always #12.5 ref_clk_in = ~ref_clk_in;

  mspsc_pin_model mspsc_pin_model_inst (.ref_clk_in, .reset_in,
    .code_in(code), .sel_out(strap_select_enable_pin_in),
    .strap_a_out(mode_strap_a_in), .strap_b_out(mode_strap_b_in));

  mspsc_ctrl #(.WAKE_CYC(WK)) mspsc_ctrl_inst (.ref_clk_in, .reset_in,
    .scan_entry_pin_in, .strap_select_enable_pin_in, .mode_strap_a_in,
    .mode_strap_b_in, .debug_program_lock_in, .overtemp_detector_in,
    .boot_done_in, .cfg_wr_in, .cfg_data_in, .resume_capable_active_in,
    .resume_src_in, .resume_clr_in, .irq_req_in, .reti_in, .wd_overflow_in,
    .wake_src_in, .wake_clr_in, .flash_ctrl_wr_in, .flash_ctrl_data_in,
    .ram_retain_in, .mode_out, .strap_latch_out, .power_state_out,
    .cpu_clk_en_out, .cpu_power_out, .periph_power_out, .ram_low_power_out,
    .periph_reset_out, .app_start_out, .start_addr_out, .wd_clear_out,
    .wake_flag_reg_out, .resume_flag_out, .flash_control_reg_out);

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude;
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [2:0] cur(input bit m);
    return m ? mode_out : power_state_out;
  endfunction

  // bounded wait at falling edges; k holds the cycles taken
  task automatic wt(input bit m, input logic [2:0] e, input int b);
    k = 0;
    do
    begin
      @(negedge ref_clk_in);
      k++;
    end
    while (cur(m) !== e && k < b);
    if (cur(m) !== e)
    begin
      n_errors++;
      $display("[FAIL] wait expected %h seen %h", e, cur(m));
      conclude();
    end
  endtask

  // one-cycle strobe on the selected input group
  task automatic pulse(input int s, input logic [9:0] v);
    @(posedge ref_clk_in);
    case (s)
      0: wake_src_in <= v[4:0];
      1: irq_req_in <= v;
      2: resume_src_in <= v[6:0];
      3: reti_in <= v[0];
      4: wd_overflow_in <= v[0];
      5: resume_clr_in <= v[6:0];
      6: flash_ctrl_wr_in <= 1'b1;
      default: cfg_wr_in <= 1'b1;
    endcase
    cfg_data_in <= v[7:0];
    flash_ctrl_data_in <= v[7:0];
    @(posedge ref_clk_in);
    {wake_src_in, irq_req_in, resume_src_in, reti_in} <= '0;
    {wd_overflow_in, resume_clr_in, flash_ctrl_wr_in, cfg_wr_in} <= '0;
  endtask

  function automatic mspsc_mode_type em(input logic [3:0] c);
    if (!c[3])
      return MODE_NORMAL;
    case (c[2:1])
      STRAP_TEST: return MODE_TEST;
      STRAP_FLASH_PROGRAM_BIT: return c[0] ? MODE_NORMAL : MODE_FLASH_PROGRAM_BIT;
      STRAP_DEBUG: return c[0] ? MODE_NORMAL : MODE_DEBUG;
      default: return MODE_NORMAL;
    endcase
  endfunction

  // c = {select enable, strap a, strap b, lock}
  task automatic rst(input logic [3:0] c);
    @(posedge ref_clk_in);
    code <= c[3:1];
    debug_program_lock_in <= c[0];
    reset_in <= 1'b1;
    repeat (10) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    wt(1'b1, em(c), 80);
    chk("sample time", k >= STRAP_SAMPLE_CYC, 1'b1);
    chk("strap latch", strap_latch_out, c[2:1]);
    pulse(6, 10'h00c);
    @(negedge ref_clk_in);
    chk("flash", flash_control_reg_out,
        (em(c) == MODE_NORMAL || em(c) == MODE_DEBUG) ? 8'h00 : 8'h0c);
  endtask

  initial
  begin
    for (int i = 0; i < 16; i++)
      rst(i[3:0]);
    wt(1'b0, PS_RUN, 20);
    chk("start", start_addr_out, APP_START_ADDR);
    pulse(0, 10'h001);
    @(negedge ref_clk_in);
    chk("run wake", {wake_flag_reg_out, power_state_out}, {7'h01, PS_RUN});
    pulse(7, 10'h020);
    repeat (3) @(negedge ref_clk_in);
    chk("idle refused", power_state_out, PS_RUN);
    @(posedge ref_clk_in);
    resume_capable_active_in <= 1'b1;
    pulse(7, 10'h020);
    wt(1'b0, PS_IDLE, 3);
    chk("idle entry", {wd_clear_out, cpu_clk_en_out}, 2'h2);
    pulse(0, 10'h002);
    @(negedge ref_clk_in);
    chk("idle wake", {wake_flag_reg_out, power_state_out}, {7'h03, PS_IDLE});
    for (int i = 0; i < IRQ_W; i++)
    begin
      pulse(1, 10'h001 << i);
      wt(1'b0, PS_RUN, 3);
      pulse(3, 10'h001);
      wt(1'b0, PS_IDLE, 3);
    end
    for (int i = 0; i < RESUME_W; i++)
    begin
      pulse(2, 10'h001 << i);
      wt(1'b0, PS_RUN, 3);
      chk("resume", resume_flag_out, (16'h0002 << i) - 16'h0001);
      pulse(7, 10'h020);
      wt(1'b0, PS_IDLE, 3);
    end
    pulse(1, 10'h004);
    wt(1'b0, PS_RUN, 3);
    pulse(2, 10'h001);
    pulse(3, 10'h001);
    repeat (3) @(negedge ref_clk_in);
    chk("reti after resume", power_state_out, PS_RUN);
    pulse(5, 10'h07f);
    @(negedge ref_clk_in);
    chk("resume clear", resume_flag_out, 16'h0000);
    pulse(7, 10'h080);
    wt(1'b0, PS_SLEEP, 3);
    chk("sleep", {wake_flag_reg_out, cpu_power_out, periph_power_out,
        ram_low_power_out}, 16'h0000);
    @(posedge ref_clk_in);
    ram_retain_in <= 1'b1;
    @(negedge ref_clk_in);
    chk("ram retain", ram_low_power_out, 1'b1);
    pulse(0, 10'h010);
    wt(1'b0, PS_WAKE, 3);
    wt(1'b0, PS_INIT, 20);
    chk("wake time", k >= WK - 1 && k <= WK + 1, 1'b1);
    wt(1'b0, PS_RUN, 5);
    chk("restart", {wake_flag_reg_out, app_start_out, wd_clear_out},
        {7'h10, 2'h3});
    pulse(4, 10'h001);
    wt(1'b0, PS_INIT, 3);
    chk("watchdog", {wake_flag_reg_out, mode_out}, {7'h30, MODE_NORMAL});
    chk("init reset", periph_reset_out, 1'b1);
    wt(1'b0, PS_RUN, 5);
    @(posedge ref_clk_in);
    overtemp_detector_in <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    pulse(7, 10'h040);
    wt(1'b0, PS_THERM, 3);
    pulse(0, 10'h001);
    repeat (3) @(negedge ref_clk_in);
    chk("hot", {wake_flag_reg_out, power_state_out}, {7'h00, PS_THERM});
    @(posedge ref_clk_in);
    overtemp_detector_in <= 1'b0;
    wt(1'b0, PS_INIT, 10);
    chk("cooled", wake_flag_reg_out, 16'h0040);
    wt(1'b0, PS_RUN, 5);
    pulse(7, 10'h040);
    wt(1'b0, PS_INIT, 10);
    @(posedge ref_clk_in);
    scan_entry_pin_in <= 1'b1;
    wt(1'b1, MODE_SCAN, 10);
    conclude();
  end
endmodule

// *** dv/mspsc_pin_model.sv ***
`timescale 1ns/1ps
module mspsc_pin_model
  import mspsc_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  input  wire logic [2:0] code_in,
  output logic            sel_out,
  output logic            strap_a_out,
  output logic            strap_b_out
);
  int hold = 0;
  initial
  begin
    {sel_out, strap_a_out, strap_b_out} = 3'h0;
  end
  // straps stay put well past the sampling window, then toggle as gpio use
  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      hold <= STRAP_SAMPLE_CYC + 8;
      {sel_out, strap_a_out, strap_b_out} <= code_in;
    end
    else if (hold > 0)
      hold <= hold - 1;
    else
    begin
      strap_a_out <= ~strap_a_out;
      strap_b_out <= ~strap_b_out;
    end
  end
endmodule

// *** rtl/mspsc_ctrl.sv ***
`timescale 1ns/1ps
// Operation
// - latch both straps at end of sampling window, hold them
// - mode from select pin and strap pair
// - lock bit turns program/debug into normal
// - scan pin high forces scan mode, after pin synchroniser delay
// - wait one sampling period before operating
// - normal/debug block setting program and erase
// - init resets peripherals, boots, starts at 4000h
// - run keeps state on wakeups, sets flags
// - idle stops cpu clock, resume returns run
// - idle entry clears watchdog, wakeups flag only
// - interrupt leaves idle; return re-enters idle unless a resume source was seen
// - record resume sources in resume flags
// - idle accepts all listed interrupt requests
// - power-down keeps controller and retained memory
// - clear wake flags entering sleep or thermal
// - thermal halt waits only on cooldown
// - idle write needs active resume-capable peripheral
// - watchdog overflow reinitialises, keeps normal mode
// - thermal halt bit enters thermal shutdown
// - power-down entered only by software bit
// - wakeup restarts in run after wake delay
module mspsc_ctrl
  import mspsc_pkg::*;
#(
  parameter int WAKE_CYC = mspsc_pkg::WAKE_DELAY_CYC
)
(
  input  wire logic                          ref_clk_in,
  input  wire logic                          reset_in,
  input  wire logic                          scan_entry_pin_in,
  input  wire logic                          strap_select_enable_pin_in,
  input  wire logic                          mode_strap_a_in,
  input  wire logic                          mode_strap_b_in,
  input  wire logic                          debug_program_lock_in,
  input  wire logic                          overtemp_detector_in,
  input  wire logic                          boot_done_in,
  input  wire logic                          cfg_wr_in,
  input  wire logic [7:0]                    cfg_data_in,
  input  wire logic                          resume_capable_active_in,
  input  wire logic [mspsc_pkg::RESUME_W-1:0]   resume_src_in,
  input  wire logic [mspsc_pkg::RESUME_W-1:0]   resume_clr_in,
  input  wire logic [mspsc_pkg::IRQ_W-1:0]      irq_req_in,
  input  wire logic                          reti_in,
  input  wire logic                          wd_overflow_in,
  input  wire logic [mspsc_pkg::WAKE_SRC_W-1:0] wake_src_in,
  input  wire logic [mspsc_pkg::WAKE_FLAG_W-1:0] wake_clr_in,
  input  wire logic                          flash_ctrl_wr_in,
  input  wire logic [7:0]                    flash_ctrl_data_in,
  input  wire logic                          ram_retain_in,
  output mspsc_pkg::mspsc_mode_type          mode_out,
  output logic [1:0]                         strap_latch_out,
  output mspsc_pkg::mspsc_pwr_type           power_state_out,
  output logic                               cpu_clk_en_out,
  output logic                               cpu_power_out,
  output logic                               periph_power_out,
  output logic                               ram_low_power_out,
  output logic                               periph_reset_out,
  output logic                               app_start_out,
  output logic [15:0]                        start_addr_out,
  output logic                               wd_clear_out,
  output logic [mspsc_pkg::WAKE_FLAG_W-1:0]  wake_flag_reg_out,
  output logic [mspsc_pkg::RESUME_W-1:0]     resume_flag_out,
  output logic [7:0]                         flash_control_reg_out
);
  import mspsc_pkg::*;

  logic                    scan_lvl;
  logic                    select_lvl;
  logic                    strap_a_lvl;
  logic                    strap_b_lvl;
  logic                    hot_lvl;
  logic [SAMPLE_CNT_W-1:0] sample_cnt;
  logic [WAKE_CNT_W-1:0]   wake_cnt;
  logic                    woke;
  logic                    isr_from_idle;
  logic                    resume_seen;
  logic                    any_resume;
  logic                    any_irq;
  logic                    any_wake;
  logic                    block_mode;
  logic                    power_off;
  logic                    sleep_req;
  logic                    therm_req;
  logic                    idle_req;
  logic [1:0]              strap_now;
  mspsc_mode_type          next_mode;

  mspsc_flag_if #(.W(WAKE_FLAG_W)) wake_if ();
  mspsc_flag_if #(.W(RESUME_W))    resume_if ();

  mspsc_pin_sync u_scan_sync (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .pin_in     (scan_entry_pin_in),
    .level_out  (scan_lvl)
  );
  mspsc_pin_sync u_select_sync (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .pin_in     (strap_select_enable_pin_in),
    .level_out  (select_lvl)
  );
  mspsc_pin_sync u_strap_a_sync (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .pin_in     (mode_strap_a_in),
    .level_out  (strap_a_lvl)
  );
  mspsc_pin_sync u_strap_b_sync (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .pin_in     (mode_strap_b_in),
    .level_out  (strap_b_lvl)
  );
  mspsc_pin_sync u_hot_sync (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .pin_in     (overtemp_detector_in),
    .level_out  (hot_lvl)
  );

  mspsc_flag_reg #(.W(WAKE_FLAG_W)) u_wake_flags (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .port       (wake_if.owner)
  );
  mspsc_flag_reg #(.W(RESUME_W)) u_resume_flags (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .port       (resume_if.owner)
  );

  assign strap_now  = {strap_a_lvl, strap_b_lvl};
  assign any_resume = |resume_src_in;
  assign any_irq    = |irq_req_in;
  assign any_wake   = |wake_src_in;
  assign block_mode = (mode_out == MODE_NORMAL) ||
                      (mode_out == MODE_DEBUG);
  assign sleep_req  = cfg_wr_in && cfg_data_in[CFG_SLEEP_BIT];
  assign therm_req  = cfg_wr_in && cfg_data_in[CFG_THERMAL_BIT];
  assign idle_req   = cfg_wr_in && cfg_data_in[CFG_IDLE_BIT];

  // mode decode from the sampled pins
  always_comb
  begin
    next_mode = MODE_NORMAL;
    if (select_lvl)
    begin
      unique case (strap_now)
        STRAP_TEST:  next_mode = MODE_TEST;
        STRAP_FLASH_PROGRAM_BIT:  next_mode = debug_program_lock_in ?
                                 MODE_NORMAL : MODE_FLASH_PROGRAM_BIT;
        STRAP_DEBUG: next_mode = debug_program_lock_in ?
                                 MODE_NORMAL : MODE_DEBUG;
        default:     next_mode = MODE_NORMAL;
      endcase
    end
  end

  // mode selection after reset, scan entry at any time
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      mode_out        <= MODE_BOOT;
      sample_cnt      <= '0;
      strap_latch_out <= 2'h0;
    end
    else if (scan_lvl)
      mode_out <= MODE_SCAN;
    else if (mode_out == MODE_BOOT)
    begin
      if (sample_cnt == SAMPLE_CNT_W'(STRAP_SAMPLE_CYC - 1))
      begin
        strap_latch_out <= strap_now;
        mode_out        <= next_mode;
      end
      else
        sample_cnt <= sample_cnt + 1'b1;
    end
  end

  // flash control register, setting program/erase blocked in normal/debug
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      flash_control_reg_out <= FC_RESET;
    else if (flash_ctrl_wr_in)
    begin
      flash_control_reg_out <= flash_ctrl_data_in;
      if (block_mode)
      begin
        flash_control_reg_out[FC_PROGRAM_BIT] <=
          flash_ctrl_data_in[FC_PROGRAM_BIT] &
          flash_control_reg_out[FC_PROGRAM_BIT];
        flash_control_reg_out[FC_ERASE_BIT] <=
          flash_ctrl_data_in[FC_ERASE_BIT] &
          flash_control_reg_out[FC_ERASE_BIT];
      end
    end
  end

  // power state sequencing in normal mode
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      power_state_out <= PS_HOLD;
      wake_cnt        <= '0;
      woke            <= 1'b0;
      isr_from_idle   <= 1'b0;
      resume_seen     <= 1'b0;
    end
    else if (mode_out != MODE_NORMAL)
      power_state_out <= PS_HOLD;
    else
    begin
      unique case (power_state_out)
        PS_HOLD:
          power_state_out <= PS_INIT;
        PS_INIT:
          if (boot_done_in)
            power_state_out <= PS_RUN;
        PS_RUN:
        begin
          if (any_resume)
            resume_seen <= 1'b1;
          if (wd_overflow_in)
            power_state_out <= PS_INIT;
          else if (sleep_req)
            power_state_out <= PS_SLEEP;
          else if (therm_req)
            power_state_out <= PS_THERM;
          else if (idle_req && resume_capable_active_in)
            power_state_out <= PS_IDLE;
          else if (reti_in && isr_from_idle)
          begin
            isr_from_idle <= 1'b0;
            if (!resume_seen && !any_resume)
              power_state_out <= PS_IDLE;
          end
        end
        PS_IDLE:
        begin
          if (wd_overflow_in)
            power_state_out <= PS_INIT;
          else if (any_resume)
          begin
            power_state_out <= PS_RUN;
            isr_from_idle   <= 1'b0;
          end
          else if (any_irq)
          begin
            power_state_out <= PS_RUN;
            isr_from_idle   <= 1'b1;
            resume_seen     <= 1'b0;
          end
        end
        PS_SLEEP:
          if (any_wake || wd_overflow_in)
          begin
            power_state_out <= PS_WAKE;
            wake_cnt        <= '0;
          end
        PS_WAKE:
          if (wake_cnt == WAKE_CNT_W'(WAKE_CYC - 1))
          begin
            power_state_out <= PS_INIT;
            woke            <= 1'b1;
          end
          else
            wake_cnt <= wake_cnt + 1'b1;
        PS_THERM:
          if (!hot_lvl)
          begin
            power_state_out <= PS_INIT;
            woke            <= 1'b1;
          end
      endcase
      if (power_state_out == PS_INIT && boot_done_in)
        woke <= 1'b0;
    end
  end

  // init pulses, start vector and watchdog clears
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      app_start_out  <= 1'b0;
      start_addr_out <= 16'h0000;
      wd_clear_out   <= 1'b0;
    end
    else
    begin
      app_start_out <= 1'b0;
      wd_clear_out  <= 1'b0;
      if (mode_out == MODE_NORMAL && power_state_out == PS_INIT &&
          boot_done_in)
      begin
        app_start_out  <= 1'b1;
        start_addr_out <= APP_START_ADDR;
        wd_clear_out   <= woke;
      end
      if (mode_out == MODE_NORMAL && power_state_out == PS_RUN &&
          !wd_overflow_in && !sleep_req && !therm_req &&
          ((idle_req && resume_capable_active_in) ||
           (reti_in && isr_from_idle && !resume_seen && !any_resume)))
        wd_clear_out <= 1'b1;
    end
  end

  // wake flags: sources set in any state except thermal and hold, thermal bit on cooldown, cleared on entry
  always_comb
  begin
    wake_if.set = '0;
    if (power_state_out == PS_THERM)
      wake_if.set[WF_THERMAL_BIT] = !hot_lvl;
    else if (mode_out == MODE_NORMAL && power_state_out != PS_HOLD)
    begin
      wake_if.set[WAKE_SRC_W-1:0] = wake_src_in;
      wake_if.set[WF_WATCHDOG_BIT] = wd_overflow_in;
    end
  end
  assign wake_if.clr     = wake_clr_in;
  assign wake_if.clr_all = power_state_out == PS_RUN && !wd_overflow_in &&
                           (sleep_req || therm_req);
  assign wake_flag_reg_out = wake_if.flags;

  assign resume_if.set     = resume_src_in;
  assign resume_if.clr     = resume_clr_in;
  assign resume_if.clr_all = 1'b0;
  assign resume_flag_out   = resume_if.flags;

  // power and clock gating
  assign power_off = power_state_out == PS_SLEEP ||
                     power_state_out == PS_THERM;
  assign cpu_power_out     = !power_off;
  assign periph_power_out  = !power_off;
  assign ram_low_power_out = !power_off || ram_retain_in;
  assign periph_reset_out  = mode_out == MODE_NORMAL &&
                             power_state_out == PS_INIT;
  assign cpu_clk_en_out    = (mode_out == MODE_NORMAL) ?
                             (power_state_out == PS_RUN ||
                              power_state_out == PS_INIT) :
                             (mode_out == MODE_TEST ||
                              mode_out == MODE_FLASH_PROGRAM_BIT ||
                              mode_out == MODE_DEBUG);

  a_scan_entry: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    scan_lvl |=> mode_out == MODE_SCAN)
    else $error("scan pin did not force scan mode");

  a_strap_hold: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    $past(mode_out) != MODE_BOOT |-> $stable(strap_latch_out))
    else $error("latched straps changed after sampling");

  a_sample_wait: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    $past(mode_out) == MODE_BOOT && mode_out != MODE_BOOT &&
    mode_out != MODE_SCAN |->
    $past(sample_cnt) == SAMPLE_CNT_W'(STRAP_SAMPLE_CYC - 1))
    else $error("mode chosen before sampling period ended");

  a_lock_normal: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    $past(mode_out) == MODE_BOOT && mode_out != MODE_BOOT &&
    mode_out != MODE_SCAN && $past(debug_program_lock_in) |->
    mode_out != MODE_FLASH_PROGRAM_BIT && mode_out != MODE_DEBUG)
    else $error("locked part selected program or debug mode");

  a_lock_forces: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    debug_program_lock_in |-> mode_out != MODE_FLASH_PROGRAM_BIT ##0
    (mode_out != MODE_DEBUG || $past(mode_out) == MODE_DEBUG))
    else $error("lock bit did not force normal mode");

  a_flash_block: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    $past(block_mode) |->
    !$rose(flash_control_reg_out[FC_PROGRAM_BIT]) &&
    !$rose(flash_control_reg_out[FC_ERASE_BIT]))
    else $error("program or erase bit set in blocked mode");

  a_idle_resume: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    power_state_out == PS_IDLE && mode_out == MODE_NORMAL &&
    any_resume && !wd_overflow_in && !scan_lvl
    |=> power_state_out == PS_RUN && !cpu_clk_en_out == 1'b0)
    else $error("resume did not return to run");

  a_idle_wdclr: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    $changed(power_state_out) && power_state_out == PS_IDLE
    |-> wd_clear_out)
    else $error("watchdog not cleared on idle entry");

  a_wd_init: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    wd_overflow_in && mode_out == MODE_NORMAL && !scan_lvl &&
    (power_state_out == PS_RUN || power_state_out == PS_IDLE)
    |=> power_state_out == PS_INIT && mode_out == MODE_NORMAL &&
        wake_flag_reg_out[WF_WATCHDOG_BIT])
    else $error("watchdog overflow not handled");

  a_therm_hold: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    power_state_out == PS_THERM && hot_lvl && mode_out == MODE_NORMAL &&
    !scan_lvl |=> power_state_out == PS_THERM)
    else $error("left thermal shutdown while hot");

  a_sleep_sw: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    $changed(power_state_out) && power_state_out == PS_SLEEP
    |-> $past(sleep_req))
    else $error("power-down entered without software request");

  a_sleep_flags: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    $changed(power_state_out) && power_state_out == PS_SLEEP &&
    $past(wake_src_in) == '0 && !$past(wd_overflow_in)
    |-> wake_flag_reg_out == '0)
    else $error("wake flags not cleared entering power-down");
endmodule

// *** rtl/mspsc_flag_reg.sv ***
`timescale 1ns/1ps
module mspsc_flag_reg
#(
  parameter int W = 7
)
(
  input  wire logic  ref_clk_in,
  input  wire logic  reset_in,
  mspsc_flag_if.owner port
);
  // a set in the same cycle as a clear wins
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      port.flags <= '0;
    else
      port.flags <= (port.flags & ~(port.clr | {W{port.clr_all}}))
                    | port.set;
  end
endmodule

// *** rtl/mspsc_pin_sync.sv ***
`timescale 1ns/1ps
module mspsc_pin_sync
(
  input  wire logic ref_clk_in,
  input  wire logic reset_in,
  input  wire logic pin_in,
  output logic      level_out
);
  logic stage1;
  logic stage2;
  logic stage3;

  // a change counts once the second and third stage agree
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      stage1    <= 1'b0;
      stage2    <= 1'b0;
      stage3    <= 1'b0;
      level_out <= 1'b0;
    end
    else
    begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
        level_out <= stage2;
    end
  end
endmodule
